/* sec_defs.svh */
// register map, reset values and bus codes of the soft ecc memory
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH
`define SEC_REG_STATUS      12'h000
`define SEC_REG_MASK        12'h004
`define SEC_REG_FAULT_ADDR  12'h008
`define SEC_REG_CONFIG      12'h00C
`define SEC_STS_SINGLE_BIT  0
`define SEC_STS_DOUBLE_BIT  1
`define SEC_STATUS_RESET    2'h0
`define SEC_MASK_RESET      2'h0
`define SEC_AXI_OKAY        2'h0
`define SEC_AXI_SLVERR      2'h2
`endif

/* sec_memory.sv */
// hamming secded overlay around a simple dual-port memory, with axi4-lite status regs
//
// Behaviour
// - every write stores 4 to 8 check bits beside a 1 to 64 bit word
// - check bits: 4 for 1-4, 5 for 5-11, 6 for 12-26, 7 for 27-57, 8 above
// - reads correct any single-bit fault and detect double-bit faults
// - two flags tell no fault, single corrected, double detected
// - corrected data goes out; the stored faulty word is left alone
// - no byte write enables; each write updates whole word and check bits
// - write port and read port have the same data width
// - no read reset, no output reset value, no preloaded contents
// - only simple dual-port organisation, user width at most 64 bits
// - optional write input stage and read output stage, both off by default
// - a single inject corrupts a data bit, a double inject a data bit and a check bit
// - inject inputs on a write make a later read raise the matching flag
// - the read address of a fault is output with the flags
// - inject inputs selectable: none, single only, double only, or both
// - both injects on one write: double wins, data left uncorrected
// - check bits form a hamming code over the data word
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "sec_defs.svh"
`default_nettype none
module sec_memory #(
  parameter int                  DATA_W       = 64,
  parameter int                  ADDR_W       = 10,
  parameter bit                  WR_IN_STAGE  = 1'b0,
  parameter bit                  RD_OUT_STAGE = 1'b0,
  parameter sec_pkg::sec_inject_t INJECT_MODE = sec_pkg::SEC_INJ_BOTH
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write port; whole word only, no byte enables
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              inject_single_fault,
  input  wire logic              inject_double_fault,
  // read port; same width as the write port
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_valid,
  output logic                   single_fault_flag,
  output logic                   double_fault_flag,
  output logic      [ADDR_W-1:0] fault_read_address,
  output logic                   irq,
  // axi4-lite slave
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // hamming bits needed for d data bits, never fewer than three
  function automatic int calc_r(input int d);
    int r;
    r = 7;
    for (int i = 7; i >= 3; i--) begin
      if ((1 << i) >= d + i + 1) r = i;
    end
    return r;
  endfunction : calc_r

  localparam int R     = calc_r(DATA_W);
  localparam int P     = R + 1;
  localparam int W     = DATA_W + P;
  localparam int DEPTH = 1 << ADDR_W;

  // data bits sit at non power-of-two code positions
  function automatic logic [6:0] ham_bits(input logic [DATA_W-1:0] d);
    logic [6:0] h;
    int         di;
    h  = 7'h00;
    di = 0;
    for (int pos = 1; pos < 128; pos++) begin
      if (((pos & (pos - 1)) != 0) && (di < DATA_W)) begin
        for (int i = 0; i < 7; i++) begin
          if (((pos >> i) & 1) == 1) h[i] = h[i] ^ d[di];
        end
        di++;
      end
    end
    return h;
  endfunction : ham_bits

  // data index of a code position, -1 when it is a check position
  function automatic int data_index(input logic [6:0] syn);
    int di;
    int idx;
    di  = 0;
    idx = -1;
    for (int pos = 1; pos < 128; pos++) begin
      if (((pos & (pos - 1)) != 0) && (di < DATA_W)) begin
        if (pos == int'(syn)) idx = di;
        di++;
      end
    end
    return idx;
  endfunction : data_index

  // write side optional input stage
  logic              w_en;
  logic [ADDR_W-1:0] w_addr;
  logic [DATA_W-1:0] w_data;
  logic              w_sgl;
  logic              w_dbl;
  logic              inj_sgl;
  logic              inj_dbl;

  // unused inject inputs are forced low
  assign inj_sgl = inject_single_fault &&
                   (INJECT_MODE == sec_pkg::SEC_INJ_SINGLE ||
                    INJECT_MODE == sec_pkg::SEC_INJ_BOTH);
  assign inj_dbl = inject_double_fault &&
                   (INJECT_MODE == sec_pkg::SEC_INJ_DOUBLE ||
                    INJECT_MODE == sec_pkg::SEC_INJ_BOTH);

  generate
    if (WR_IN_STAGE) begin : g_win
      logic              en_q;
      logic [ADDR_W-1:0] addr_q;
      logic [DATA_W-1:0] data_q;
      logic              sgl_q;
      logic              dbl_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          en_q  <= 1'b0;
          sgl_q <= 1'b0;
          dbl_q <= 1'b0;
        end else begin
          en_q  <= wr_en;
          sgl_q <= inj_sgl;
          dbl_q <= inj_dbl;
        end
      end
      always_ff @(posedge aclk) begin
        addr_q <= wr_addr;
        data_q <= wr_data;
      end
      assign w_en   = en_q;
      assign w_addr = addr_q;
      assign w_data = data_q;
      assign w_sgl  = sgl_q;
      assign w_dbl  = dbl_q;
    end else begin : g_wdir
      assign w_en   = wr_en;
      assign w_addr = wr_addr;
      assign w_data = wr_data;
      assign w_sgl  = inj_sgl;
      assign w_dbl  = inj_dbl;
    end
  endgenerate

  // encode: word = {overall parity, hamming bits, data}
  logic [R-1:0] w_ham;
  logic [W-1:0] w_word;
  logic [W-1:0] w_flip;
  logic [6:0]   w_ham_all;

  assign w_ham_all = ham_bits(w_data);
  assign w_ham     = w_ham_all[R-1:0];

  always_comb begin
    w_flip = '0;
    // double flips a data bit and a check bit, and wins over single
    if (w_dbl) begin
      w_flip[0]      = 1'b1;
      w_flip[DATA_W] = 1'b1;
    end else if (w_sgl) begin
      w_flip[0] = 1'b1;
    end
  end

  assign w_word = {^{w_ham, w_data}, w_ham, w_data} ^ w_flip;

  // storage: no reset and no initial contents, so faults persist
  logic [W-1:0]      mem [DEPTH];
  logic [W-1:0]      raw_q;
  logic [ADDR_W-1:0] raddr_q;
  logic              rvld_q;

  // a read of the address being written returns the old word
  always_ff @(posedge aclk) begin
    if (w_en) mem[w_addr] <= w_word;
  end

  always_ff @(posedge aclk) begin
    if (rd_en) begin
      raw_q   <= mem[rd_addr];
      raddr_q <= rd_addr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) rvld_q <= 1'b0;
    else          rvld_q <= rd_en;
  end

  // decode; correction only touches the output path
  logic [DATA_W-1:0] raw_data;
  logic [R-1:0]      syn;
  logic              perr;
  logic [DATA_W-1:0] dec_data;
  logic              dec_sgl;
  logic              dec_dbl;
  logic [6:0]        r_ham_all;

  assign raw_data  = raw_q[DATA_W-1:0];
  assign r_ham_all = ham_bits(raw_data);
  assign syn       = r_ham_all[R-1:0] ^ raw_q[DATA_W +: R];
  assign perr      = ^raw_q;

  // a parity fault whose syndrome names a check bit leaves the data as read
  always_comb begin
    int idx;
    idx      = data_index(7'(syn));
    dec_data = raw_data;
    dec_sgl  = perr;
    dec_dbl  = !perr && (syn != '0);
    if (perr && idx >= 0) dec_data[idx] = ~raw_data[idx];
  end

  // read side optional output stage
  generate
    if (RD_OUT_STAGE) begin : g_rout
      logic [DATA_W-1:0] data_q;
      logic [ADDR_W-1:0] addr_q;
      logic              vld_q;
      logic              sgl_q;
      logic              dbl_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          vld_q <= 1'b0;
          sgl_q <= 1'b0;
          dbl_q <= 1'b0;
        end else begin
          vld_q <= rvld_q;
          sgl_q <= rvld_q && dec_sgl;
          dbl_q <= rvld_q && dec_dbl;
        end
      end
      always_ff @(posedge aclk) begin
        data_q <= dec_data;
        addr_q <= raddr_q;
      end
      assign rd_data            = data_q;
      assign rd_valid           = vld_q;
      assign single_fault_flag  = sgl_q;
      assign double_fault_flag  = dbl_q;
      assign fault_read_address = addr_q;
    end else begin : g_rdir
      assign rd_data            = dec_data;
      assign rd_valid           = rvld_q;
      assign single_fault_flag  = rvld_q && dec_sgl;
      assign double_fault_flag  = rvld_q && dec_dbl;
      assign fault_read_address = raddr_q;
    end
  endgenerate

  // status, mask, captured fault address
  logic [1:0]        status_q;
  logic [1:0]        mask_q;
  logic [ADDR_W-1:0] flt_addr_q;
  logic [1:0]        events;
  logic              wr_take;
  logic [1:0]        w1c;

  assign events  = {double_fault_flag, single_fault_flag};
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign w1c     = (wr_take && s_axi_awaddr == `SEC_REG_STATUS && s_axi_wstrb[0])
                   ? s_axi_wdata[1:0] : 2'h0;

  // a new fault in the clearing cycle stays set
  // the mask only gates irq; status records every fault
  always_ff @(posedge aclk) begin
    if (!aresetn) status_q <= `SEC_STATUS_RESET;
    else          status_q <= (status_q & ~w1c) | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= `SEC_MASK_RESET;
    end else if (wr_take && s_axi_awaddr == `SEC_REG_MASK && s_axi_wstrb[0]) begin
      mask_q <= s_axi_wdata[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)       flt_addr_q <= '0;
    else if (|events)   flt_addr_q <= fault_read_address;
  end

  assign irq = |(status_q & mask_q);

  // axi4-lite write: address and data are taken together, answer next cycle
  logic [1:0]  bresp_q;
  logic        bvalid_q;

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SEC_AXI_OKAY;
    end else if (wr_take) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (s_axi_awaddr == `SEC_REG_STATUS || s_axi_awaddr == `SEC_REG_MASK)
                  ? `SEC_AXI_OKAY : `SEC_AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // axi4-lite read
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q;
  logic        rd_take;

  assign rd_take       = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `SEC_AXI_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `SEC_AXI_OKAY;
      case (s_axi_araddr)
        `SEC_REG_STATUS:     rdata_q <= {30'h0, status_q};
        `SEC_REG_MASK:       rdata_q <= {30'h0, mask_q};
        `SEC_REG_FAULT_ADDR: rdata_q <= 32'(flt_addr_q);
        // check-bit count minus four needs three bits once words reach 58 bits
        `SEC_REG_CONFIG:     rdata_q <= {16'h0, 8'(DATA_W), 2'(INJECT_MODE),
                                         1'b0, RD_OUT_STAGE, WR_IN_STAGE, 3'(P - 4)};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `SEC_AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : sec_memory
`default_nettype wire

/* sec_memory_chk.sv */
// port checker for the soft ecc memory
`timescale 1ns/1ns
`default_nettype none
module sec_memory_chk #(
  parameter int ADDR_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic              rd_valid,
  input  wire logic              single_fault_flag,
  input  wire logic              double_fault_flag,
  input  wire logic [ADDR_W-1:0] fault_read_address,
  input  wire logic              s_axi_awvalid,
  input  wire logic              s_axi_wvalid,
  input  wire logic              s_axi_awready,
  input  wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [31:0]       s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // assumes no output stage, as the bench builds it
  a_read_answer: assert property (rd_en |=> rd_valid) else $error("read not answered");
  a_valid_cause: assert property (rd_valid |-> $past(rd_en)) else $error("stray valid");
  a_flags_apart: assert property (!(single_fault_flag && double_fault_flag))
    else $error("both fault flags");
  a_flag_aligned: assert property ((single_fault_flag || double_fault_flag) |-> rd_valid)
    else $error("flag without data");
  a_fault_addr: assert property (rd_valid |-> fault_read_address == $past(rd_addr))
    else $error("wrong fault address");
  a_bresp_follows: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : sec_memory_chk
bind sec_memory sec_memory_chk #(.ADDR_W(ADDR_W)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid),
  .single_fault_flag(single_fault_flag), .double_fault_flag(double_fault_flag),
  .fault_read_address(fault_read_address), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

/* sec_pkg.sv */
// types shared by the soft ecc memory
package sec_pkg;
  typedef enum logic [1:0] {
    SEC_INJ_NONE,
    SEC_INJ_SINGLE,
    SEC_INJ_DOUBLE,
    SEC_INJ_BOTH
  } sec_inject_t;
endpackage : sec_pkg

/* sec_user.sv */
// user logic model on the memory write and read ports
`timescale 1ns/1ns
`default_nettype none
module sec_user #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 10
) (
  input  wire logic              aclk,
  output logic                   wr_en,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [DATA_W-1:0] wr_data,
  output logic                   inject_single_fault,
  output logic                   inject_double_fault,
  output logic                   rd_en,
  output logic      [ADDR_W-1:0] rd_addr
);
  initial begin
    {wr_en, wr_addr, wr_data, inject_single_fault, inject_double_fault, rd_en, rd_addr} = '0;
  end
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic s,
                     input logic dd);
    @(posedge aclk);
    wr_en               <= 1'b1;
    wr_addr             <= a;
    wr_data             <= d;
    inject_single_fault <= s;
    inject_double_fault <= dd;
    @(posedge aclk);
    // released lines show the inverse so a late sample cannot match
    wr_en               <= 1'b0;
    wr_addr             <= ~a;
    wr_data             <= ~d;
    inject_single_fault <= 1'b0;
    inject_double_fault <= 1'b0;
  endtask : put
  task automatic get(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge aclk);
    rd_en   <= 1'b0;
    rd_addr <= ~a;
  endtask : get
endmodule : sec_user
`default_nettype wire

/* test_soft_ecc_sdp_memory.sv */
// self-checking bench for the soft ecc memory
`timescale 1ns/1ns
`include "sec_defs.svh"
`default_nettype none
module test_soft_ecc_sdp_memory;
  logic aclk = 1'b0, aresetn = 1'b0, wr_en, inj_s, inj_d, rd_en, rd_valid, sff, dff, irq;
  logic [9:0] wr_addr, rd_addr, fra;
  logic [15:0] wr_data, rd_data;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [15:0] pat [4] = '{16'h0000, 16'hFFFF, 16'hA5C3, 16'h8001};
  int n_errors = 0, checks = 0;
  always #50 aclk = ~aclk;
  sec_memory #(.DATA_W(16), .ADDR_W(10)) i_dut (.aclk(aclk), .aresetn(aresetn), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .inject_single_fault(inj_s),
    .inject_double_fault(inj_d), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .single_fault_flag(sff), .double_fault_flag(dff),
    .fault_read_address(fra), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sec_user #(.DATA_W(16), .ADDR_W(10)) i_user (.aclk(aclk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .inject_single_fault(inj_s), .inject_double_fault(inj_d),
    .rd_en(rd_en), .rd_addr(rd_addr));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    // each channel is released on its own ready
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_done) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wready === 1'b1 && !w_done) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    // ready raised late so a held response is exercised too
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    r = rresp;
    d = rdata;
    rready <= 1'b0;
  endtask : axi_rd
  // flags packed as {double, single}
  task automatic mem_rd(input logic [9:0] a, input logic [15:0] v, input logic [1:0] f);
    i_user.get(a);
    do @(posedge aclk); while (rd_valid !== 1'b1);
    check({4'h0, rd_data, fra, dff, sff}, {4'h0, v, a, f});
  endtask : mem_rd
  task automatic final_report;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`SEC_REG_CONFIG);
    check(d, 32'h0000_10C2);
    axi_rd(`SEC_REG_STATUS);
    check({r, d[1:0], irq}, 5'h00);
    axi_rd(12'h010);
    check({r, d}, {`SEC_AXI_SLVERR, 32'h0});
    axi_wr(`SEC_REG_CONFIG, 32'h0);
    check(r, `SEC_AXI_SLVERR);
    $display("register test done");
    // whole words written with an idle cycle between writes, then read with no fault
    for (int i = 0; i < 4; i++) i_user.put(10'(i), pat[i], 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) mem_rd(10'(i), pat[i], 2'b00);
    $display("clean data test done");
    i_user.put(10'h003, 16'h1234, 1'b1, 1'b0);
    i_user.put(10'h005, 16'h5678, 1'b0, 1'b1);
    i_user.put(10'h3FF, 16'h9ABC, 1'b1, 1'b1);
    mem_rd(10'h003, 16'h1234, 2'b01);
    mem_rd(10'h003, 16'h1234, 2'b01);
    mem_rd(10'h005, 16'h5679, 2'b10);
    mem_rd(10'h3FF, 16'h9ABD, 2'b10);
    axi_rd(`SEC_REG_FAULT_ADDR);
    check(d, 32'h0000_03FF);
    $display("fault inject test done");
    axi_rd(`SEC_REG_STATUS);
    check({d, irq}, 33'h6);
    axi_wr(`SEC_REG_MASK, 32'h1);
    check({r, irq}, 3'h1);
    axi_wr(`SEC_REG_STATUS, 32'h1);
    axi_rd(`SEC_REG_STATUS);
    check({d, irq}, 33'h4);
    $display("interrupt test done");
    // registers clear on a mid-run reset, stored words stay
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`SEC_REG_STATUS);
    check({r, d, irq}, 35'h0);
    axi_rd(`SEC_REG_MASK);
    check({r, d}, 34'h0);
    mem_rd(10'h001, pat[1], 2'b00);
    $display("reset test done");
    final_report();
  end
endmodule : test_soft_ecc_sdp_memory
`default_nettype wire
